//--- rtl/flash_self_program_ctrl.sv
// host side of a flash self-programming controller: software orders
// commands over AXI4-Lite, the block drives the device's control register
// and store/load strobes; device inputs are synchronous to mclk
`timescale 1ns/100ps

module flash_self_program_ctrl
    import flash_host_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // axi4-lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // device pins
    output dev_out_t dev_o,
    input wire dev_in_t dev_i
);

    logic aw_got_q, w_got_q, bvalid_q, rvalid_q, start_q, refused_q;
    logic irq_en_q, erased_ok_q, do_wr, busy, conc_busy;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q, bmask, rdata_q, ptr_word, data_word;
    logic [1:0] bresp_q;
    logic [15:0] ptr_q, data_q, z_d, sd_d;
    logic [7:0] rd_byte_q, ctl_d;
    logic [6:0] erased_page_q;
    logic [WORDS-1:0] loaded_q;
    logic [5:0] word_idx;
    logic [6:0] page_idx;
    logic [3:0] wstrb_q;
    op_t op_q;
    state_t state_q;

    // write channel: address and data taken in either order
    assign awready = !aw_got_q;
    assign wready = !w_got_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign do_wr = aw_got_q && w_got_q && !bvalid_q;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_strb
            assign bmask[gi*8 +: 8] = {8{wstrb_q[gi]}};
        end
    endgenerate

    assign ptr_word = ({16'h0000, ptr_q} & ~bmask) | (wdata_q & bmask);
    assign data_word = ({16'h0000, data_q} & ~bmask) | (wdata_q & bmask);

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= WORD_ZERO;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= awaddr[ADDR_W-1:0];
            end
            if (wvalid && wready)
            begin
                w_got_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (do_wr)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end
        end
    end

    // register writes; a command while busy is dropped without setting refused_q, not queued
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            ptr_q <= 16'h0000;
            data_q <= 16'h0000;
            op_q <= OP_ERASE;
            irq_en_q <= 1'b0;
            start_q <= 1'b0;
        end
        else
        begin
            start_q <= 1'b0;
            if (bvalid_q && bready)
                bvalid_q <= 1'b0;
            if (do_wr)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= RESP_OKAY;
                if (awaddr_q == ADDR_CMD)
                begin
                    if (!busy && !start_q && wstrb_q[0])
                    begin
                        op_q <= op_t'(wdata_q[CMD_OP_MSB:0]);
                        start_q <= 1'b1;
                    end
                    if (wstrb_q[1])
                        irq_en_q <= wdata_q[CMD_IRQ_EN_POS];
                end
                else if (awaddr_q == ADDR_PTR)
                    ptr_q <= ptr_word[15:0];
                else if (awaddr_q == ADDR_DATA)
                    data_q <= data_word[15:0];
                else if (awaddr_q != ADDR_STAT)
                    bresp_q <= RESP_SLVERR;
            end
        end
    end

    // read channel, one read at a time
    assign arready = !rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= WORD_ZERO;
            rresp <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid_q <= 1'b1;
            rresp <= RESP_OKAY;
            rdata_q <= WORD_ZERO;
            if (araddr[ADDR_W-1:0] == ADDR_CMD)
            begin
                rdata_q[CMD_OP_MSB:0] <= op_q;
                rdata_q[CMD_IRQ_EN_POS] <= irq_en_q;
            end
            else if (araddr[ADDR_W-1:0] == ADDR_PTR)
                rdata_q[15:0] <= ptr_q;
            else if (araddr[ADDR_W-1:0] == ADDR_DATA)
                rdata_q[15:0] <= data_q;
            else if (araddr[ADDR_W-1:0] == ADDR_STAT)
            begin
                rdata_q[7:0] <= rd_byte_q;
                rdata_q[STAT_CTL_LSB +: 8] <= dev_i.ctl_rdata;
                rdata_q[STAT_BUSY_POS] <= busy;
                rdata_q[STAT_REFUSED_POS] <= refused_q;
            end
            else
                rresp <= RESP_SLVERR;
        end
        else if (rvalid_q && rready)
            rvalid_q <= 1'b0;
    end

    // pointer and data as presented to the device for each command
    assign word_idx = ptr_q[WORD_MSB:WORD_LSB];
    assign page_idx = ptr_q[PAGE_MSB:PAGE_LSB];
    assign busy = state_q != ST_IDLE;
    assign conc_busy = dev_i.ctl_rdata[CTL_BUSY_POS]
        && (ptr_q < CONC_LIMIT);

    always_comb
    begin
        z_d = ptr_q;
        sd_d = data_q;
        ctl_d = CTL_LOAD;
        case (op_q)
            OP_ERASE:
            begin
                z_d = ptr_q & PAGE_MASK;
                ctl_d = CTL_ERASE;
            end
            OP_LOAD:
            begin
                z_d = ptr_q & WORD_MASK;
                ctl_d = CTL_LOAD;
            end
            OP_WRITE:
            begin
                z_d = ptr_q & PAGE_MASK;
                ctl_d = CTL_WRITE;
            end
            OP_LOCK:
            begin
                z_d = LOCK_PTR;
                sd_d = {BYTE_ONES, data_q[7:0] | LOCK_FILL};
                ctl_d = CTL_LOCK;
            end
            OP_REEN:
                ctl_d = CTL_REEN;
            OP_FUSE:
            begin
                z_d = ptr_q & FUSE_MASK;
                ctl_d = CTL_LOCK;
            end
            default:
                ctl_d = CTL_LOAD;
        endcase
        ctl_d[CTL_IRQ_EN_POS] = irq_en_q;
    end

    // command sequencer; control write and strobe are one cycle apart,
    // well inside the device's three and four cycle windows
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_q <= ST_IDLE;
            dev_o <= '0;
            refused_q <= 1'b0;
            rd_byte_q <= 8'h00;
        end
        else
        begin
            dev_o.ctl_wr <= 1'b0;
            dev_o.spm_exec <= 1'b0;
            dev_o.lpm_exec <= 1'b0;
            case (state_q)
                ST_IDLE:
                    if (start_q)
                    begin
                        if ((op_q == OP_LOAD && loaded_q[word_idx])
                            || (op_q == OP_WRITE && !(erased_ok_q
                            && erased_page_q == page_idx))
                            || (op_q == OP_READ && conc_busy)
                            || op_q > OP_READ)
                            refused_q <= 1'b1;
                        else
                        begin
                            refused_q <= 1'b0;
                            state_q <= ST_WAIT;
                        end
                    end
                ST_WAIT:
                    // store enable stays set while the device is busy
                    if (!dev_i.ctl_rdata[CTL_STORE_EN_POS]
                        && !dev_i.eeprom_write_active
                        && !dev_i.cpu_halt)
                    begin
                        dev_o.z_ptr <= z_d;
                        dev_o.spm_data <= sd_d;
                        if (op_q == OP_READ)
                        begin
                            dev_o.lpm_exec <= 1'b1;
                            state_q <= ST_EXEC;
                        end
                        else
                        begin
                            dev_o.ctl_wr <= 1'b1;
                            dev_o.ctl_wdata <= ctl_d;
                            state_q <= ST_CTL;
                        end
                    end
                ST_CTL:
                begin
                    if (op_q == OP_FUSE)
                        dev_o.lpm_exec <= 1'b1;
                    else
                        dev_o.spm_exec <= 1'b1;
                    state_q <= ST_EXEC;
                end
                ST_EXEC:
                    state_q <= (op_q == OP_FUSE || op_q == OP_READ)
                        ? ST_CAPT : ST_IDLE;
                ST_CAPT:
                begin
                    rd_byte_q <= dev_i.lpm_rdata;
                    state_q <= ST_IDLE;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // shadow of the device buffer: which words were loaded, which page
    // was erased; any order of loads is fine
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            loaded_q <= '0;
            erased_ok_q <= 1'b0;
            erased_page_q <= 7'h00;
        end
        else if (dev_o.spm_exec)
        begin
            if (op_q == OP_LOAD)
                loaded_q[dev_o.z_ptr[WORD_MSB:WORD_LSB]] <= 1'b1;
            else if (op_q == OP_WRITE || op_q == OP_REEN)
            begin
                loaded_q <= '0;
                erased_ok_q <= 1'b0;
            end
            else if (op_q == OP_ERASE)
            begin
                erased_ok_q <= 1'b1;
                erased_page_q <= dev_o.z_ptr[PAGE_MSB:PAGE_LSB];
            end
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    store_follows_a: assert property (
        dev_o.ctl_wr && op_q != OP_FUSE |=> dev_o.spm_exec)
        else $error("store strobe did not follow control write");
    load_follows_a: assert property (
        dev_o.ctl_wr && op_q == OP_FUSE |=> dev_o.lpm_exec
        ##2 rd_byte_q == $past(dev_i.lpm_rdata))
        else $error("lock read not issued or captured");
    page_ptr_a: assert property (
        dev_o.spm_exec && (op_q == OP_ERASE || op_q == OP_WRITE)
        |-> (dev_o.z_ptr & ~PAGE_MASK) == 16'h0000)
        else $error("page pointer has stray bits");
    lock_ptr_a: assert property (
        dev_o.spm_exec && op_q == OP_LOCK |-> dev_o.z_ptr == LOCK_PTR
        && (dev_o.spm_data[7:0] & LOCK_FILL) == LOCK_FILL)
        else $error("lock set pointer or filler wrong");
    eeprom_idle_a: assert property (
        $rose(dev_o.ctl_wr) |-> !$past(dev_i.eeprom_write_active))
        else $error("control written during eeprom write");
    single_load_a: assert property (
        dev_o.spm_exec && op_q == OP_LOAD
        |-> !loaded_q[dev_o.z_ptr[WORD_MSB:WORD_LSB]])
        else $error("buffer word loaded twice");
    erase_first_a: assert property (
        dev_o.spm_exec && op_q == OP_WRITE |-> erased_ok_q
        && erased_page_q == dev_o.z_ptr[PAGE_MSB:PAGE_LSB])
        else $error("page write without matching erase");
    store_idle_a: assert property (
        $rose(dev_o.ctl_wr) |-> !$past(dev_i.ctl_rdata[CTL_STORE_EN_POS]))
        else $error("control written while store enable set");
    buffer_clear_a: assert property (
        dev_o.spm_exec && (op_q == OP_WRITE || op_q == OP_REEN)
        |=> loaded_q == '0)
        else $error("buffer shadow not cleared");

    cover_erase_c: cover property (dev_o.spm_exec && op_q == OP_ERASE);
    cover_write_c: cover property (dev_o.spm_exec && op_q == OP_WRITE);
    cover_fuse_c: cover property (state_q == ST_CAPT && op_q == OP_FUSE);
    cover_refuse_c: cover property ($rose(refused_q));

endmodule

//--- pkg/flash_host_pkg.sv
// constants, field layouts and carrier types of the flash self-programming
// host; assumes the device's control register and pointer layout below
package flash_host_pkg;

    // own register map, byte offsets on the AXI4-Lite slave
    localparam logic [3:0] ADDR_CMD = 4'h0;
    localparam logic [3:0] ADDR_PTR = 4'h4;
    localparam logic [3:0] ADDR_DATA = 4'h8;
    localparam logic [3:0] ADDR_STAT = 4'hC;
    localparam int ADDR_W = 4;

    // command register fields
    localparam int CMD_OP_MSB = 2;
    localparam int CMD_IRQ_EN_POS = 8;

    // status register fields
    localparam int STAT_CTL_LSB = 8;
    localparam int STAT_BUSY_POS = 16;
    localparam int STAT_REFUSED_POS = 17;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // device control values, low five bits
    localparam logic [7:0] CTL_ERASE = 8'h03;
    localparam logic [7:0] CTL_LOAD = 8'h01;
    localparam logic [7:0] CTL_WRITE = 8'h05;
    localparam logic [7:0] CTL_LOCK = 8'h09;
    localparam logic [7:0] CTL_REEN = 8'h11;
    localparam int CTL_IRQ_EN_POS = 7;
    localparam int CTL_BUSY_POS = 6;
    localparam int CTL_STORE_EN_POS = 0;

    // pointer layout: word index Z[6:1], page index Z[13:7]
    localparam int WORD_LSB = 1;
    localparam int WORD_MSB = 6;
    localparam int PAGE_LSB = 7;
    localparam int PAGE_MSB = 13;
    localparam int WORDS = 64;
    localparam logic [15:0] PAGE_MASK = 16'h3F80;
    localparam logic [15:0] WORD_MASK = 16'h007E;
    localparam logic [15:0] FUSE_MASK = 16'h0003;
    localparam logic [15:0] LOCK_PTR = 16'h0001;
    localparam logic [7:0] LOCK_FILL = 8'hC3;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    // byte addresses below this belong to the concurrent-read section
    localparam logic [15:0] CONC_LIMIT = 16'h3800;

    typedef enum logic [2:0] {
        OP_ERASE = 3'h0,
        OP_LOAD = 3'h1,
        OP_WRITE = 3'h2,
        OP_LOCK = 3'h3,
        OP_REEN = 3'h4,
        OP_FUSE = 3'h5,
        OP_READ = 3'h6
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT = 3'b001,
        ST_CTL = 3'b011,
        ST_EXEC = 3'b010,
        ST_CAPT = 3'b110
    } state_t;

    typedef struct packed {
        logic ctl_wr;
        logic [7:0] ctl_wdata;
        logic spm_exec;
        logic lpm_exec;
        logic [15:0] z_ptr;
        logic [15:0] spm_data;
    } dev_out_t;

    typedef struct packed {
        logic [7:0] ctl_rdata;
        logic [7:0] lpm_rdata;
        logic eeprom_write_active;
        logic cpu_halt;
    } dev_in_t;

endpackage

//--- test/flash_dev_model.sv
// behavioural model of the flash self-programming device: control register,
// timed store/load windows, busy section, halt, lock and fuse bytes
// assumes dev_o is registered on mclk; ee_busy comes from the bench
`timescale 1ns/100ps
module flash_dev_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0] FUSE_LO = 8'hE1,
    parameter logic [7:0] FUSE_HI = 8'h99,
    parameter int BUSY_CYC = 16
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // pins
    input wire dev_out_t dev_o,
    input wire logic ee_busy,
    output dev_in_t dev_i
);
    logic [7:0] ctl_q, lock_q, rd_q;
    logic [2:0] win_q;
    logic [4:0] run_q;
    logic halt_q;
    logic ok_code;
    assign ok_code = dev_o.ctl_wdata[4:0] inside {5'h11, 5'h09, 5'h05,
        5'h03, 5'h01};
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ctl_q <= 8'h00;
            lock_q <= 8'hFF;
            win_q <= 3'h0;
            run_q <= 5'h00;
            halt_q <= 1'b0;
        end
        else if (dev_o.ctl_wr && !ee_busy && !ctl_q[0] && ok_code)
        begin
            ctl_q <= {dev_o.ctl_wdata[7], ctl_q[6], 1'b0,
                dev_o.ctl_wdata[4:0]};
            win_q <= 3'h4;
        end
        else if (dev_o.spm_exec && ctl_q[0] && win_q != 3'h0)
        begin
            win_q <= 3'h0;
            case (ctl_q[4:0])
                5'h03, 5'h05:
                begin
                    run_q <= 5'(BUSY_CYC);
                    if (dev_o.z_ptr < CONC_LIMIT)
                        ctl_q[6] <= 1'b1;
                    else
                        halt_q <= 1'b1;
                end
                5'h09:
                begin
                    lock_q <= lock_q & {2'b11, dev_o.spm_data[5:2], 2'b11};
                    ctl_q[4:0] <= 5'h00;
                end
                5'h11:
                begin
                    ctl_q[6] <= 1'b0;
                    ctl_q[4:0] <= 5'h00;
                end
                default: ctl_q[4:0] <= 5'h00;
            endcase
        end
        else if (dev_o.lpm_exec && ctl_q[3] && win_q > 3'h1)
        begin
            ctl_q[4:0] <= 5'h00;
            win_q <= 3'h0;
        end
        else if (run_q != 5'h00)
        begin
            run_q <= run_q - 5'h01;
            if (run_q == 5'h01)
            begin
                ctl_q[4:0] <= 5'h00;
                halt_q <= 1'b0;
            end
        end
        else if (win_q != 3'h0)
        begin
            win_q <= win_q - 3'h1;
            if (win_q == 3'h1)
                ctl_q[4:0] <= 5'h00;
        end
    end
    // outside lock mode a load returns a pattern of the address
    always_ff @(posedge mclk)
    begin
        if (dev_o.lpm_exec)
        begin
            if (ctl_q[3] && win_q > 3'h1)
                rd_q <= dev_o.z_ptr == 16'h0001 ? lock_q :
                    dev_o.z_ptr == 16'h0003 ? FUSE_HI :
                    dev_o.z_ptr == 16'h0000 ? FUSE_LO : 8'hFF;
            else
                rd_q <= dev_o.z_ptr[7:0] ^ 8'h5A;
        end
    end
    assign dev_i.ctl_rdata = ctl_q;
    assign dev_i.lpm_rdata = rd_q;
    assign dev_i.eeprom_write_active = ee_busy;
    assign dev_i.cpu_halt = halt_q;
endmodule

//--- test/tb_top.sv
// self-checking bench: AXI4-Lite master, device model, pin monitor
// assumes the host's register map and command codes of the package
`timescale 1ns/100ps
module tb_top
    import flash_host_pkg::*;
;
    localparam logic [7:0] F_LO = 8'hE1;
    localparam logic [7:0] F_HI = 8'h99;
    typedef struct packed {
        logic [2:0] op;
        logic [15:0] ptr, dat;
        logic [7:0] ctl;
        logic [15:0] z;
        logic spm;
        logic [7:0] rb;
    } row_t;
    logic mclk, sys_rst, ee_busy;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata, st;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    dev_out_t dev_o;
    dev_in_t dev_i;
    logic [7:0] cap_ctl;
    logic [15:0] cap_z, cap_d;
    logic cap_spm, prev_wr;
    int n_errors = 0, cmp_count = 0, n_ctl = 0, n_lpm = 0, cyc = 0;
    int n0, m0, i;
    row_t rows[9];
    flash_self_program_ctrl uut (.mclk(mclk), .sys_rst(sys_rst),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .dev_o(dev_o), .dev_i(dev_i));
    flash_dev_model #(.FUSE_LO(F_LO), .FUSE_HI(F_HI), .BUSY_CYC(16)) dev (
        .mclk(mclk), .sys_rst(sys_rst), .dev_o(dev_o), .ee_busy(ee_busy),
        .dev_i(dev_i));
    task automatic chk(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, s);
            n_errors++;
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        awaddr <= {28'h0, a};
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bready && bvalid)
            begin
                r = bresp;
                bready <= 1'b0;
            end
        end while (awvalid || wvalid || bready);
    endtask
    task automatic axr(input logic [3:0] a, output logic [31:0] d);
        araddr <= {28'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rready && rvalid)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end while (arvalid || rready);
    endtask
    // issue a command and poll until the host is idle again
    task automatic iss(input logic [2:0] op, input logic [15:0] p, d,
        input logic irq);
        int k;
        n0 = n_ctl;
        axw(ADDR_PTR, {16'h0, p});
        axw(ADDR_DATA, {16'h0, d});
        axw(ADDR_CMD, {23'h0, irq, 5'h0, op});
        st = 32'h0001_0000;
        for (k = 0; k < 100 && st[16] !== 1'b0; k++)
            axr(ADDR_STAT, st);
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            tally_and_finish();
        end
        if (!sys_rst)
        begin
            if (dev_o.ctl_wr)
            begin
                cap_ctl <= dev_o.ctl_wdata;
                cap_z <= dev_o.z_ptr;
                cap_d <= dev_o.spm_data;
                n_ctl <= n_ctl + 1;
                if (dev_i.cpu_halt | dev_i.eeprom_write_active | dev_i.ctl_rdata[0])
                    chk("ctl_while_busy", 1, 0);
            end
            if (prev_wr)
            begin
                cap_spm <= dev_o.spm_exec;
                chk("strobe_follows", dev_o.spm_exec ^ dev_o.lpm_exec, 1);
            end
            if (dev_o.lpm_exec)
                n_lpm <= n_lpm + 1;
        end
        prev_wr <= dev_o.ctl_wr;
    end
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, ee_busy} = 6'h00;
        {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
        wstrb = 4'h0;
        sys_rst = 1'b1;
        rows[0] = {3'h1, 16'h0047, 16'h1234, 8'h01, 16'h0046, 1'b1, 8'h00};
        rows[1] = {3'h0, 16'h0080, 16'h0000, 8'h03, 16'h0080, 1'b1, 8'h00};
        rows[2] = {3'h1, 16'h0002, 16'hABCD, 8'h01, 16'h0002, 1'b1, 8'h00};
        rows[3] = {3'h2, 16'h0080, 16'h0000, 8'h05, 16'h0080, 1'b1, 8'h00};
        rows[4] = {3'h4, 16'h0000, 16'h0000, 8'h11, 16'h0000, 1'b1, 8'h00};
        rows[5] = {3'h3, 16'h0000, 16'h00EB, 8'h09, 16'h0001, 1'b1, 8'h00};
        rows[6] = {3'h5, 16'h0000, 16'h0000, 8'h09, 16'h0000, 1'b0, F_LO};
        rows[7] = {3'h5, 16'h0003, 16'h0000, 8'h09, 16'h0003, 1'b0, F_HI};
        rows[8] = {3'h5, 16'h0001, 16'h0000, 8'h09, 16'h0001, 1'b0, 8'hEB};
        repeat (12) @(posedge mclk);
        chk("dev_o_reset", {31'h0, |dev_o}, WORD_ZERO);
        chk("ready_reset", {awready, wready, arready}, 3'h7);
        sys_rst <= 1'b0;
        @(posedge mclk);
        axr(ADDR_STAT, st);
        chk("stat_reset", st, WORD_ZERO);
        $display("test reset done");
        for (i = 0; i < 9; i++)
        begin
            iss(rows[i].op, rows[i].ptr, rows[i].dat, 1'b0);
            chk("ctl_count", n_ctl - n0, 1);
            chk("ctl", cap_ctl, rows[i].ctl);
            chk("z_ptr", cap_z, rows[i].z);
            chk("store_strobe", cap_spm, rows[i].spm);
            if (rows[i].op == 3'h1 || rows[i].op == 3'h3)
                chk("spm_data", cap_d, rows[i].dat | (rows[i].op == 3'h3 ?
                    16'hFFC3 : 16'h0));
            if (rows[i].op == 3'h5)
                chk("read_byte", st[7:0], rows[i].rb);
        end
        $display("test command table done");
        iss(3'h1, 16'h0046, 16'h5555, 1'b0);
        chk("load_after_clear", n_ctl - n0, 1);
        iss(3'h1, 16'h0046, 16'h5555, 1'b0);
        chk("reload_refused", {st[17], 8'(n_ctl - n0)}, 9'h100);
        iss(3'h2, 16'h0080, 16'h0000, 1'b0);
        chk("write_no_erase", {st[17], 8'(n_ctl - n0)}, 9'h100);
        iss(3'h7, 16'h0000, 16'h0000, 1'b0);
        chk("bad_op", {st[17], 8'(n_ctl - n0)}, 9'h100);
        $display("test refusals done");
        iss(3'h0, 16'h0100, 16'h0000, 1'b0);
        iss(3'h6, 16'h0010, 16'h0000, 1'b0);
        chk("busy_flag", st[14], 1'b1);
        chk("read_blocked", {st[17], 8'(n_ctl - n0)}, 9'h100);
        iss(3'h4, 16'h0000, 16'h0000, 1'b0);
        m0 = n_lpm;
        iss(3'h6, 16'h0010, 16'h0000, 1'b0);
        chk("plain_read", {st[17], st[14], st[7:0]}, 10'h04A);
        chk("plain_strobe", {8'(n_lpm - m0), cap_ctl}, 16'h0111);
        $display("test section busy done");
        // erase in the no-concurrent-read section, so the device halts us
        axw(ADDR_PTR, 32'h0000_3800);
        ee_busy <= 1'b1;
        m0 = n_ctl;
        axw(ADDR_CMD, {23'h0, 1'b1, 8'h00});
        repeat (30) @(posedge mclk);
        chk("eeprom_hold", n_ctl - m0, 0);
        ee_busy <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("halt_irq", {dev_i.cpu_halt, cap_ctl}, 9'h183);
        iss(3'h1, 16'h0010, 16'h0F0F, 1'b0);
        chk("halt_wait", {st[17], cap_z}, 17'h00010);
        chk("irq_ctl", n_ctl - m0, 2);
        axr(ADDR_PTR, st);
        chk("ptr_back", st, 32'h0000_0010);
        axr(ADDR_CMD, st);
        chk("cmd_back", st, 32'h0000_0001);
        axw(4'h2, WORD_ZERO);
        chk("unmapped", r, RESP_SLVERR);
        axr(4'h2, st);
        chk("unmapped_rd", r, RESP_SLVERR);
        $display("test eeprom halt done");
        tally_and_finish();
    end
endmodule
